// ==== async_rx_defines.svh ====
// constants for the asynchronous serial receiver
`ifndef ASYNC_RX_DEFINES_SVH
`define ASYNC_RX_DEFINES_SVH

// register byte offsets
`define RX_CTRL_OFF 12'h000
`define RX_STAT_OFF 12'h004
`define RX_DATA_OFF 12'h008
`define RX_IRQ_OFF 12'h00C

// control register fields
`define CTRL_PORT_EN 0
`define CTRL_RX_EN 1
`define CTRL_CLK_MODE 2
`define CTRL_NINE 3
`define CTRL_PIN_DIR 4
`define CTRL_RESET 32'h0000_0000

// status register fields
`define STAT_PENDING 0
`define STAT_FRAMING_ERROR_FLAG 1
`define STAT_OVERRUN_ERROR_FLAG 2
`define STAT_NINTH 3
`define STAT_IDLE 4

// irq gate register fields
`define IRQ_RX_EN 0
`define IRQ_PERIPH 1
`define IRQ_GLOBAL 2

// oversampling
`define OVS_LAST 4'hF
`define OVS_HALF 4'h7
`define OVS_V0 4'h6
`define OVS_V1 4'h7
`define OVS_V2 4'h8

// index of the last data bit in eight- and nine-bit characters
`define LAST_BIT_EIGHT 4'h7
`define LAST_BIT_NINE 4'h8

`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

`endif

// ==== async_rx_pkg.sv ====
// types shared by the asynchronous serial receiver
package async_rx_pkg;
	typedef enum logic [2:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_STOP
	} rx_state_t;
endpackage

// ==== async_serial_receiver.sv ====
// asynchronous serial receiver with AXI4-Lite register access
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "async_rx_defines.svh"
module async_serial_receiver #(
	parameter int DEPTH = 2
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic baud_tick_x16,
	input wire logic rx_data_pin_in,
	output logic rx_data_pin_oe_n,
	output logic rx_irq
);
	if (DEPTH != 2)
	begin : g_depth_check
		$error("async_serial_receiver: overrun logic assumes DEPTH of 2");
	end

	// register state
	logic [4:0] ctrl_r, ctrl_nxt;
	logic [2:0] gate_r, gate_nxt;
	logic port_en, rx_en, clk_mode, nine_sel;
	assign port_en = ctrl_r[`CTRL_PORT_EN];
	assign rx_en = ctrl_r[`CTRL_RX_EN];
	assign clk_mode = ctrl_r[`CTRL_CLK_MODE];
	assign nine_sel = ctrl_r[`CTRL_NINE];

	logic rx_active;
	assign rx_active = port_en && rx_en && !clk_mode;

	// pin direction: forced input while receiver active, else pin_direction_bit
	always_comb
	begin
		rx_data_pin_oe_n = 1'b1;
		if (!rx_active)
			rx_data_pin_oe_n = ctrl_r[`CTRL_PIN_DIR];
	end

	// receiver core
	logic char_done, char_framing_error_flag;
	logic [8:0] char_data;
	logic core_idle;
	logic ovr_r, ovr_nxt;

	rx_bit_engine u_engine (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(rx_active && !ovr_r),
		.tick(baud_tick_x16),
		.rx_in(rx_data_pin_in),
		.nine_bit(nine_sel),
		.done(char_done),
		.data(char_data),
		.framing_error_flag(char_framing_error_flag),
		.idle(core_idle)
	);

	// receive buffer: {framing_error_flag, ninth, data}
	logic fifo_empty, fifo_full, fifo_pop, fifo_push, fifo_flush;
	logic [9:0] head;

	assign fifo_flush = !port_en;
	assign fifo_push = char_done && !fifo_full;

	rx_char_fifo #(
		.WIDTH(10),
		.DEPTH(DEPTH)
	) u_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.flush(fifo_flush),
		.push(fifo_push),
		.push_data({char_framing_error_flag, char_data}),
		.pop(fifo_pop),
		.head_data(head),
		.empty(fifo_empty),
		.full(fifo_full)
	);

	// overrun: third character finishing while two are held
	always_comb
	begin
		ovr_nxt = ovr_r;
		if (char_done && fifo_full)
			ovr_nxt = 1'b1;
		if (!rx_en || !port_en)
			ovr_nxt = 1'b0;
	end

	// status of the character taken by the last data read; software reads it after the data
	logic framing_error_flag_seen_r, framing_error_flag_seen_nxt, ninth_seen_r, ninth_seen_nxt;
	always_comb
	begin
		framing_error_flag_seen_nxt = framing_error_flag_seen_r;
		ninth_seen_nxt = ninth_seen_r;
		if (fifo_pop && !fifo_empty)
		begin
			framing_error_flag_seen_nxt = head[9];
			ninth_seen_nxt = head[8];
		end
		if (!port_en)
		begin
			framing_error_flag_seen_nxt = 1'b0;
			ninth_seen_nxt = 1'b0;
		end
	end

	logic pending;
	assign pending = !fifo_empty;
	assign rx_irq = pending && gate_r[`IRQ_RX_EN] && gate_r[`IRQ_PERIPH]
		&& gate_r[`IRQ_GLOBAL];

	// AXI4-Lite slave
	logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
	logic [11:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic do_write, do_read;

	function automatic logic mapped(input logic [11:0] a);
		return a == `RX_CTRL_OFF || a == `RX_STAT_OFF || a == `RX_DATA_OFF
			|| a == `RX_IRQ_OFF;
	endfunction

	assign s_axi_awready = !aw_hold_r && !bvalid_r;
	assign s_axi_wready = !w_hold_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	logic aw_have, w_have;
	logic [11:0] waddr;
	logic [31:0] wdat;
	logic [3:0] wstb;
	assign aw_have = aw_hold_r || (s_axi_awvalid && s_axi_awready);
	assign w_have = w_hold_r || (s_axi_wvalid && s_axi_wready);
	assign waddr = aw_hold_r ? awaddr_r : s_axi_awaddr;
	assign wdat = w_hold_r ? wdata_r : s_axi_wdata;
	assign wstb = w_hold_r ? wstrb_r : s_axi_wstrb;
	assign do_write = aw_have && w_have && !bvalid_r;
	assign do_read = s_axi_arvalid && s_axi_arready;
	assign fifo_pop = do_read && s_axi_araddr == `RX_DATA_OFF;

	always_comb
	begin
		aw_hold_nxt = aw_hold_r;
		w_hold_nxt = w_hold_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		ctrl_nxt = ctrl_r;
		gate_nxt = gate_r;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_hold_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_hold_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (bvalid_r && s_axi_bready)
			bvalid_nxt = 1'b0;
		if (do_write)
		begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = mapped(waddr) ? `AXI_OKAY : `AXI_SLVERR;
			// status and data are read-only; writes there change nothing
			if (waddr == `RX_CTRL_OFF && wstb[0])
				ctrl_nxt = wdat[4:0];
			if (waddr == `RX_IRQ_OFF && wstb[0])
				gate_nxt = wdat[2:0];
		end
	end

	always_comb
	begin
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (rvalid_r && s_axi_rready)
			rvalid_nxt = 1'b0;
		if (do_read)
		begin
			rvalid_nxt = 1'b1;
			rresp_nxt = mapped(s_axi_araddr) ? `AXI_OKAY : `AXI_SLVERR;
			rdata_nxt = '0;
			unique case (s_axi_araddr)
				`RX_CTRL_OFF: rdata_nxt[4:0] = ctrl_r;
				`RX_IRQ_OFF: rdata_nxt[2:0] = gate_r;
				`RX_DATA_OFF: rdata_nxt[7:0] = fifo_empty ? 8'h00 : head[7:0];
				`RX_STAT_OFF:
				begin
					rdata_nxt[`STAT_PENDING] = pending;
					// an empty read keeps the last status, so repeated reads do not clear it
					rdata_nxt[`STAT_FRAMING_ERROR_FLAG] = framing_error_flag_seen_r;
					rdata_nxt[`STAT_NINTH] = ninth_seen_r;
					rdata_nxt[`STAT_OVERRUN_ERROR_FLAG] = ovr_r;
					rdata_nxt[`STAT_IDLE] = core_idle;
				end
				default: rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r <= 5'(`CTRL_RESET);
			gate_r <= '0;
			ovr_r <= 1'b0;
			framing_error_flag_seen_r <= 1'b0;
			ninth_seen_r <= 1'b0;
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			bvalid_r <= 1'b0;
			bresp_r <= `AXI_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= `AXI_OKAY;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			gate_r <= gate_nxt;
			ovr_r <= ovr_nxt;
			framing_error_flag_seen_r <= framing_error_flag_seen_nxt;
			ninth_seen_r <= ninth_seen_nxt;
			aw_hold_r <= aw_hold_nxt;
			w_hold_r <= w_hold_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	a_irq_gating: assert property (@(posedge aclk) disable iff (!aresetn)
		rx_irq |-> (pending && gate_r == 3'b111))
		else $error("interrupt without all enables");
	a_pin_input: assert property (@(posedge aclk) disable iff (!aresetn)
		rx_active |-> rx_data_pin_oe_n)
		else $error("pin driven while receiver active");
	a_overrun_set: assert property (@(posedge aclk) disable iff (!aresetn)
		(char_done && fifo_full && rx_en && port_en) |=> ovr_r)
		else $error("overrun not flagged");
	a_overrun_block: assert property (@(posedge aclk) disable iff (!aresetn)
		ovr_r |-> !fifo_push)
		else $error("character accepted during overrun");
	a_overrun_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		!rx_en |=> !ovr_r)
		else $error("overrun survived receive disable");
	a_port_reset: assert property (@(posedge aclk) disable iff (!aresetn)
		!port_en |=> fifo_empty)
		else $error("buffer not cleared on port disable");
	a_framing_error_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		!port_en |=> !framing_error_flag_seen_r)
		else $error("framing status survived port disable");
	a_push_pending: assert property (@(posedge aclk) disable iff (!aresetn)
		(fifo_push && !fifo_flush) |=> pending)
		else $error("pending not set after push");
	a_pop_drain: assert property (@(posedge aclk) disable iff (!aresetn)
		(fifo_pop && !fifo_push && !fifo_full) |=> fifo_empty)
		else $error("data read did not remove character");
endmodule
`default_nettype wire

// ==== async_serial_receiver_tb_top.sv ====
// self-checking bench for the asynchronous serial receiver
`timescale 1ns/10ps
`default_nettype none
`include "async_rx_defines.svh"
`define check_eq(nm, got, exp) \
	begin \
		check_count++; \
		if ((got) !== (exp)) \
		begin \
			num_errors++; \
			$display("Error %s expected %h seen %h", nm, exp, got); \
		end \
	end
module async_serial_receiver_tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, rd;
	logic [1:0] resp;
	logic baud_tick_x16 = 1'b0;
	logic [1:0] tick_cnt = 2'h0;
	logic rx_line, rx_data_pin_oe_n, rx_irq;
	int num_errors = 0, check_count = 0, cycles = 0, seed = 32'h0000_5a09;
	logic [9:0] q[$];
	logic [1:0] popped = 2'b00;
	logic m_ovr = 1'b0, rx_on = 1'b0, nine = 1'b0;
	logic [2:0] gates = 3'h0;
	logic [8:0] d;
	async_serial_receiver #(.DEPTH(2)) DUT (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .baud_tick_x16(baud_tick_x16),
		.rx_data_pin_in(rx_line), .rx_data_pin_oe_n(rx_data_pin_oe_n), .rx_irq(rx_irq)
	);
	serial_tx_model DRV (.aclk(aclk), .tick(baud_tick_x16), .line(rx_line));
	always #2.5 aclk = ~aclk;
	// one oversampling tick every four clocks keeps a character near 700 cycles
	always @(posedge aclk)
	begin
		tick_cnt <= tick_cnt + 2'h1;
		baud_tick_x16 <= (tick_cnt == 2'h3);
		cycles++;
		if (cycles == 40000)
		begin
			num_errors++;
			results();
		end
	end
	task automatic results();
		$display("comparisons %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
		logic aw_left, w_left;
		aw_left = 1'b1;
		w_left = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw_left || w_left)
		begin
			@(posedge aclk);
			if (aw_left && s_axi_awready === 1'b1)
			begin
				aw_left = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_left && s_axi_wready === 1'b1)
			begin
				w_left = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do
			@(posedge aclk);
		while (s_axi_bvalid !== 1'b1);
		`check_eq("bresp", s_axi_bresp, `AXI_OKAY)
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic axi_rd(input logic [11:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
			@(posedge aclk);
		while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do
			@(posedge aclk);
		while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rx_char(input logic [8:0] v, input logic stop_bit);
		DRV.send(v, nine ? 9 : 8, stop_bit, 1 + ($random(seed) & 31));
		if (rx_on && !m_ovr)
		begin
			if (q.size() == 2)
				m_ovr = 1'b1;
			else
				q.push_back({~stop_bit, v});
		end
		repeat (4) @(posedge aclk);
	endtask
	task automatic check_status();
		logic [31:0] e;
		axi_rd(`RX_STAT_OFF);
		e = {27'h0, 1'b1, popped[0], m_ovr, popped[1], q.size() != 0};
		`check_eq("status", rd, e)
		`check_eq("rx_irq", rx_irq, q.size() != 0 && gates == 3'h7)
	endtask
	task automatic pop_check();
		axi_rd(`RX_DATA_OFF);
		`check_eq("data", rd, q.size() ? {24'h0, q[0][7:0]} : 32'h0000_0000)
		if (q.size())
		begin
			popped = q[0][9:8];
			void'(q.pop_front());
		end
		check_status();
	endtask
	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(`RX_CTRL_OFF);
		`check_eq("ctrl_reset", rd, `CTRL_RESET)
		axi_rd(12'h010);
		`check_eq("unmapped", {resp, rd}, {`AXI_SLVERR, 32'h0000_0000})
		check_status();
		$display("test reset done");
		axi_wr(`RX_CTRL_OFF, 32'h0000_0001);
		`check_eq("oe_n_off", rx_data_pin_oe_n, 1'b0)
		gates = 3'h7;
		axi_wr(`RX_IRQ_OFF, 32'h0000_0007);
		axi_wr(`RX_CTRL_OFF, 32'h0000_0003);
		rx_on = 1'b1;
		`check_eq("oe_n", rx_data_pin_oe_n, 1'b1)
		for (int i = 0; i < 4; i++)
		begin
			rx_char(9'($random(seed)) & 9'h0FF, 1'b1);
			pop_check();
		end
		rx_char(9'h055, 1'b0);
		rx_char(9'h0A3, 1'b1);
		pop_check();
		pop_check();
		DRV.glitch();
		check_status();
		$display("test framing done");
		rx_char(9'h03C, 1'b1);
		for (int g = 0; g < 8; g++)
		begin
			gates = g[2:0];
			axi_wr(`RX_IRQ_OFF, {29'h0, gates});
			`check_eq("irq_gate", rx_irq, gates == 3'h7)
		end
		axi_wr(`RX_STAT_OFF, 32'h0000_0000);
		check_status();
		pop_check();
		$display("test irq done");
		repeat (4)
			rx_char(9'($random(seed)) & 9'h0FF, 1'b1);
		check_status();
		pop_check();
		pop_check();
		check_status();
		axi_wr(`RX_CTRL_OFF, 32'h0000_0001);
		m_ovr = 1'b0;
		rx_on = 1'b0;
		rx_char(9'h0E7, 1'b1);
		check_status();
		axi_wr(`RX_CTRL_OFF, 32'h0000_0003);
		rx_on = 1'b1;
		rx_char(9'h018, 1'b1);
		pop_check();
		$display("test overrun done");
		axi_wr(`RX_CTRL_OFF, 32'h0000_000B);
		nine = 1'b1;
		rx_char(9'h1A5, 1'b1);
		rx_char(9'h05A, 1'b1);
		pop_check();
		pop_check();
		rx_char(9'($random(seed)) & 9'h1FF, 1'b0);
		pop_check();
		rx_char(9'($random(seed)) & 9'h1FF, 1'b0);
		axi_wr(`RX_CTRL_OFF, 32'h0000_0000);
		q.delete();
		popped = 2'b00;
		rx_on = 1'b0;
		axi_rd(`RX_STAT_OFF);
		`check_eq("port_off", rd[2:0], 3'h0)
		$display("test nine bit and port reset done");
		results();
	end
endmodule
`default_nettype wire

// ==== rx_bit_engine.sv ====
// start detect, majority sampling and framing for one character
`timescale 1ns/10ps
`default_nettype none
`include "async_rx_defines.svh"
module rx_bit_engine (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire logic tick,
	input wire logic rx_in,
	input wire logic nine_bit,
	output logic done,
	output logic [8:0] data,
	output logic framing_error_flag,
	output logic idle
);
	async_rx_pkg::rx_state_t st_r, st_nxt;
	logic [3:0] ovs_r, ovs_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [8:0] shf_r, shf_nxt;
	logic [2:0] vote_r, vote_nxt;
	logic prev_r, prev_nxt;
	logic done_r, done_nxt, framing_error_flag_r, framing_error_flag_nxt;
	logic [8:0] data_r, data_nxt;
	logic maj;

	assign maj = (vote_r[0] & vote_r[1]) | (vote_r[0] & vote_r[2]) | (vote_r[1] & vote_r[2]);
	assign done = done_r;
	assign data = data_r;
	assign framing_error_flag = framing_error_flag_r;
	assign idle = (st_r == async_rx_pkg::RX_IDLE);

	always_comb
	begin
		st_nxt = st_r;
		ovs_nxt = ovs_r;
		bit_nxt = bit_r;
		shf_nxt = shf_r;
		vote_nxt = vote_r;
		// edge is judged between two tick samples; a per-clock history misses edges between ticks
		prev_nxt = prev_r;
		if (tick)
			prev_nxt = rx_in;
		done_nxt = 1'b0;
		framing_error_flag_nxt = framing_error_flag_r;
		data_nxt = data_r;
		if (!enable)
			st_nxt = async_rx_pkg::RX_IDLE;
		else if (tick)
		begin
			ovs_nxt = ovs_r + 4'h1;
			if (ovs_r == `OVS_V0)
				vote_nxt[0] = rx_in;
			if (ovs_r == `OVS_V1)
				vote_nxt[1] = rx_in;
			if (ovs_r == `OVS_V2)
				vote_nxt[2] = rx_in;
			unique case (st_r)
				async_rx_pkg::RX_IDLE:
				begin
					ovs_nxt = '0;
					if (prev_r && !rx_in)
						st_nxt = async_rx_pkg::RX_START;
				end
				async_rx_pkg::RX_START:
					if (ovs_r == `OVS_HALF && rx_in)
						st_nxt = async_rx_pkg::RX_IDLE;
					else if (ovs_r == `OVS_LAST)
					begin
						// counter wraps here, so votes land one full bit after the start centre
						st_nxt = async_rx_pkg::RX_DATA;
						bit_nxt = '0;
					end
				async_rx_pkg::RX_DATA:
					if (ovs_r == `OVS_LAST)
					begin
						// vote is taken around the bit centre
						shf_nxt = nine_bit ? {maj, shf_r[8:1]} : {1'b0, maj, shf_r[7:1]};
						bit_nxt = bit_r + 4'h1;
						if (bit_r == (nine_bit ? `LAST_BIT_NINE : `LAST_BIT_EIGHT))
							st_nxt = async_rx_pkg::RX_STOP;
					end
				async_rx_pkg::RX_STOP:
					if (ovs_r == `OVS_LAST)
					begin
						framing_error_flag_nxt = !maj;
						data_nxt = shf_r;
						done_nxt = 1'b1;
						st_nxt = async_rx_pkg::RX_IDLE;
					end
				default: st_nxt = async_rx_pkg::RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r <= async_rx_pkg::RX_IDLE;
			ovs_r <= '0;
			bit_r <= '0;
			shf_r <= '0;
			vote_r <= '0;
			prev_r <= 1'b1;
			done_r <= 1'b0;
			framing_error_flag_r <= 1'b0;
			data_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
			ovs_r <= ovs_nxt;
			bit_r <= bit_nxt;
			shf_r <= shf_nxt;
			vote_r <= vote_nxt;
			prev_r <= prev_nxt;
			done_r <= done_nxt;
			framing_error_flag_r <= framing_error_flag_nxt;
			data_r <= data_nxt;
		end
	end

	a_false_start: assert property (@(posedge aclk) disable iff (!aresetn)
		(enable && tick && st_r == async_rx_pkg::RX_START && ovs_r == `OVS_HALF && rx_in)
		|=> (st_r == async_rx_pkg::RX_IDLE && !done_r))
		else $error("false start not abandoned");
	a_done_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
		done_r |=> !done_r)
		else $error("done longer than one cycle");
endmodule
`default_nettype wire

// ==== rx_char_fifo.sv ====
// two-entry receive buffer holding data, ninth bit and framing status
`timescale 1ns/10ps
`default_nettype none
module rx_char_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 2
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic flush,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	input wire logic pop,
	output logic [WIDTH-1:0] head_data,
	output logic empty,
	output logic full
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_depth_check
		$error("rx_char_fifo: DEPTH must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] rd_r, rd_nxt, wr_r, wr_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic do_push, do_pop;

	assign empty = (cnt_r == '0);
	assign full = (cnt_r == (AW+1)'(DEPTH));
	assign do_push = push && !full;
	assign do_pop = pop && !empty;
	assign head_data = mem_r[rd_r];

	always_comb
	begin
		rd_nxt = rd_r;
		wr_nxt = wr_r;
		cnt_nxt = cnt_r;
		if (flush)
		begin
			rd_nxt = '0;
			wr_nxt = '0;
			cnt_nxt = '0;
		end
		else
		begin
			if (do_push)
				wr_nxt = wr_r + AW'(1);
			if (do_pop)
				rd_nxt = rd_r + AW'(1);
			cnt_nxt = cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_r <= '0;
			wr_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			rd_r <= rd_nxt;
			wr_r <= wr_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// storage needs no reset; the count guards every read
	always_ff @(posedge aclk)
	begin
		if (do_push && !flush)
			mem_r[wr_r] <= push_data;
	end

	a_fifo_count: assert property (@(posedge aclk) disable iff (!aresetn)
		cnt_r <= (AW+1)'(DEPTH))
		else $error("fifo count above depth");
endmodule
`default_nettype wire

// ==== serial_tx_model.sv ====
// remote serial transmitter model that drives the receive line
`timescale 1ns/10ps
`default_nettype none
module serial_tx_model (
	input wire logic aclk,
	input wire logic tick,
	output logic line
);
	initial line = 1'b1;
	task automatic wait_ticks(input int n);
		repeat (n)
		begin
			@(posedge aclk);
			while (tick !== 1'b1)
				@(posedge aclk);
		end
	endtask
	// line rests high between frames, as a pulled-up wire would
	task automatic send(input logic [8:0] d, input int nbits, input logic stop_bit, input int gap);
		line <= 1'b0;
		wait_ticks(16);
		for (int i = 0; i < nbits; i++)
		begin
			line <= d[i];
			wait_ticks(16);
		end
		line <= stop_bit;
		wait_ticks(16);
		line <= 1'b1;
		wait_ticks(gap);
	endtask
	// low pulse shorter than half a bit, must not start a character
	task automatic glitch();
		line <= 1'b0;
		wait_ticks(4);
		line <= 1'b1;
		wait_ticks(40);
	endtask
endmodule
`default_nettype wire
